// ===== logic/analog_monitor_output_scaler.sv
// Two-channel analog monitor scaler with APB register slave
`timescale 1ns/1ps
`include "ams_cfg.svh"

module analog_monitor_output_scaler (
	input  wire logic                     CORE_CLK_IN,
	input  wire logic                     SRST_IN,
	input  wire logic                     PSEL_IN,
	input  wire logic                     PENABLE_IN,
	input  wire logic                     PWRITE_IN,
	input  wire logic [17:0]              PADDR_IN,
	input  wire logic [31:0]              PWDATA_IN,
	output logic      [31:0]              PRDATA_OUT,
	output logic                          PREADY_OUT,
	output logic                          PSLVERR_OUT,
	input  wire ams_pkg::monitor_inputs_t MON_IN,
	input  wire logic                     CTRL_TICK_IN,
	output logic      [15:0]              MON1_CODE_OUT,
	output logic      [15:0]              MON2_CODE_OUT,
	output logic                          DAC_LOAD_OUT
);
	import ams_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic        [15:0] sel_q  [2];
	logic signed [15:0] off_q  [2];
	logic signed [15:0] mag_q  [2];
	logic        [15:0] code_q [2];
	logic        [15:0] out_q  [2];
	logic        [31:0] prdata_q;
	logic               pready_q;
	logic               pslverr_q;
	logic               dac_load_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic        [15:0] idx;
	logic               aligned;
	logic               access;
	logic               hit_sel1, hit_sel2, hit_off1, hit_off2, hit_mag1, hit_mag2;
	logic               hit_code1, hit_code2;
	logic               mapped;
	logic               wr_range_ok;
	logic signed [15:0] wr_val;
	logic        [31:0] rd_mux;

	// Word index and per-register hits
	assign idx       = PADDR_IN[17:2];
	assign aligned   = (PADDR_IN[1:0] == 2'h0);
	assign access    = PSEL_IN & PENABLE_IN & ~pready_q;
	assign hit_sel1  = aligned & (idx == `AMS_IDX_SEL1);
	assign hit_sel2  = aligned & (idx == `AMS_IDX_SEL2);
	assign hit_off1  = aligned & (idx == `AMS_IDX_OFF1);
	assign hit_off2  = aligned & (idx == `AMS_IDX_OFF2);
	assign hit_mag1  = aligned & (idx == `AMS_IDX_MAG1);
	assign hit_mag2  = aligned & (idx == `AMS_IDX_MAG2);
	assign hit_code1 = aligned & (idx == `AMS_IDX_CODE1);
	assign hit_code2 = aligned & (idx == `AMS_IDX_CODE2);
	assign mapped    = hit_sel1 | hit_sel2 | hit_off1 | hit_off2 | hit_mag1 | hit_mag2 | hit_code1 | hit_code2;

	// Offset and magnification writes must stay within the setting range
	assign wr_val      = PWDATA_IN[15:0];
	assign wr_range_ok = (wr_val <= $signed(`AMS_SET_LIMIT)) && (wr_val >= -$signed(`AMS_SET_LIMIT));

	// Read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_sel1)  rd_mux[15:0] = sel_q[0];
		if (hit_sel2)  rd_mux[15:0] = sel_q[1];
		if (hit_off1)  rd_mux = {{16{off_q[0][15]}}, off_q[0]};
		if (hit_off2)  rd_mux = {{16{off_q[1][15]}}, off_q[1]};
		if (hit_mag1)  rd_mux = {{16{mag_q[0][15]}}, mag_q[0]};
		if (hit_mag2)  rd_mux = {{16{mag_q[1][15]}}, mag_q[1]};
		if (hit_code1) rd_mux[15:0] = out_q[0];
		if (hit_code2) rd_mux[15:0] = out_q[1];
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= access;
			pslverr_q <= 1'b0;
			if (access) begin
				prdata_q  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
				pslverr_q <= ~mapped | (PWRITE_IN & (hit_code1 | hit_code2))
					| (PWRITE_IN & (hit_off1 | hit_off2 | hit_mag1 | hit_mag2) & ~wr_range_ok);
			end
		end
	end

	// ----------------------------------------------------------------
	// Settings, written at the completing edge and used at once
	// ----------------------------------------------------------------
	logic commit;

	assign commit = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN;

	// Selection registers
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			sel_q[0] <= `AMS_RST_SEL1;
			sel_q[1] <= `AMS_RST_SEL2;
		end else if (commit) begin
			if (hit_sel1) sel_q[0] <= PWDATA_IN[15:0];  // [RQ1]
			if (hit_sel2) sel_q[1] <= PWDATA_IN[15:0];  // [RQ1]
		end
	end

	// Offset and magnification; out-of-range writes keep the old value
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			off_q[0] <= `AMS_RST_OFF;                   // [RQ13]
			off_q[1] <= `AMS_RST_OFF;
			mag_q[0] <= `AMS_RST_MAG;                   // [RQ14]
			mag_q[1] <= `AMS_RST_MAG;
		end else if (commit & wr_range_ok) begin
			if (hit_off1) off_q[0] <= wr_val;          // [RQ13]
			if (hit_off2) off_q[1] <= wr_val;
			if (hit_mag1) mag_q[0] <= wr_val;          // [RQ14]
			if (hit_mag2) mag_q[1] <= wr_val;
		end
	end

	// ----------------------------------------------------------------
	// Quantity selection in 0.1 mV units
	// ----------------------------------------------------------------
	function automatic logic signed [47:0] pick(input logic [7:0] code, input monitor_inputs_t m);
		logic signed [47:0] r;
		r = 48'h0000_0000_0000;
		case (code)
			SEL_MOTOR_SPEED:   r = m.motor_speed * $signed(`AMS_F_SPEED);      // [RQ2]
			SEL_SPEED_REF:     r = m.speed_ref * $signed(`AMS_F_SPEED);        // [RQ2]
			SEL_POS_REF_SPEED: r = m.pos_ref_speed * $signed(`AMS_F_SPEED);    // [RQ2]
			SEL_SPEED_FF:      r = m.speed_ff * $signed(`AMS_F_SPEED);         // [RQ2]
			SEL_TORQUE_REF:    r = m.torque_ref * $signed(`AMS_F_TORQUE);      // [RQ3]
			SEL_TORQUE_FF:     r = m.torque_ff * $signed(`AMS_F_TORQUE);       // [RQ3]
			SEL_POS_DEV:       r = m.pos_ctrl ? m.pos_dev * $signed(`AMS_F_POSDEV) : 48'sh0000_0000_0000; // [RQ4]
			SEL_LOAD_DEV:      r = m.load_motor_dev * $signed(`AMS_F_LOADDEV); // [RQ4]
			SEL_POS_AMP_DEV:   r = m.pos_amp_dev * $signed(`AMS_F_POSDEV);     // [RQ5]
			SEL_POS_DONE:      r = m.pos_done ? `AMS_LVL_5V : 48'h0000_0000_0000;   // [RQ6]
			SEL_DIST_DONE:     r = m.dist_done ? `AMS_LVL_5V : 48'h0000_0000_0000;  // [RQ7]
			SEL_ACTIVE_GAIN:   r = m.gain2 ? `AMS_LVL_2V : `AMS_LVL_1V;              // [RQ8]
			SEL_EXT_SPEED:     r = m.ext_enc_speed * $signed(`AMS_F_SPEED);    // [RQ9]
			SEL_DC_BUS:        r = m.dc_bus * $signed(`AMS_F_DCBUS);           // [RQ10]
			default:           r = 48'h0000_0000_0000;  // Reserved and unknown codes give 0 V [RQ11]
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Per-channel scaling pipeline
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic signed [47:0] qty_q;
			logic signed [63:0] acc_q;
			logic signed [63:0] neg;
			logic signed [89:0] prod;
			logic signed [57:0] scaled;

			// Stage 1: pick the quantity for this channel
			always_ff @(posedge CORE_CLK_IN) begin
				if (SRST_IN) begin
					qty_q <= 48'h0000_0000_0000;
				end else begin
					qty_q <= pick(sel_q[ch][`AMS_SEL_MSB:`AMS_SEL_LSB], MON_IN);  // [RQ1]
				end
			end

			// Stage 2: quantity times magnification plus offset, both at the x100 scale
			always_ff @(posedge CORE_CLK_IN) begin
				if (SRST_IN) begin
					acc_q <= 64'h0000_0000_0000_0000;
				end else begin
					acc_q <= 64'(qty_q * mag_q[ch]) + 64'(off_q[ch] * $signed(`AMS_OFF_WEIGHT));  // [RQ12]
				end
			end

			// Invert, map +-8 V to full code span, then clamp
			assign neg    = -acc_q;                                          // [RQ12]
			assign prod   = 90'(neg * $signed({1'b0, `AMS_CODE_K}));         // [RQ16]
			assign scaled = 58'(prod >>> `AMS_CODE_SHIFT);

			// Stage 3: saturated 16-bit code
			always_ff @(posedge CORE_CLK_IN) begin
				if (SRST_IN) begin
					code_q[ch] <= 16'h0000;
				end else if (scaled > $signed({42'h000_0000_0000, `AMS_CODE_MAX})) begin
					code_q[ch] <= `AMS_CODE_MAX;                                 // [RQ17]
				end else if (scaled < -$signed({42'h000_0000_0000, `AMS_CODE_MAX}) - 58'sd1) begin
					code_q[ch] <= `AMS_CODE_MIN;                                 // [RQ17]
				end else begin
					code_q[ch] <= scaled[15:0];                                  // [RQ15]
				end
			end

			// Output code refreshed once per control cycle
			always_ff @(posedge CORE_CLK_IN) begin
				if (SRST_IN) begin
					out_q[ch] <= 16'h0000;
				end else if (CTRL_TICK_IN) begin
					out_q[ch] <= code_q[ch];                                     // [RQ18]
				end
			end
		end
	endgenerate

	// DAC load strobe marks freshly updated codes
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			dac_load_q <= 1'b0;
		end else begin
			dac_load_q <= CTRL_TICK_IN;                                          // [RQ18]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA_OUT    = prdata_q;
	assign PREADY_OUT    = pready_q;
	assign PSLVERR_OUT   = pslverr_q;
	assign MON1_CODE_OUT = out_q[0];
	assign MON2_CODE_OUT = out_q[1];
	assign DAC_LOAD_OUT  = dac_load_q;

endmodule

// ===== shared/ams_cfg.svh
// Offsets, field positions, reset values and scale constants of the analog monitor scaler
//
// Contract
// RQ1: Channel 1/2 quantity chosen by low byte of its selection register.
// RQ2: Codes 00, 01, 05, 09 scale 1 V per 1,000 min-1 or mm/s.
// RQ3: Codes 02 and 0A scale 1 V per 100 percent rated torque.
// RQ4: Code 03 at 0.05 V/unit, 0 V outside position control; 07 at 0.01 V/unit.
// RQ5: Code 04 outputs amplifier deviation at 0.05 V per encoder pulse.
// RQ6: Code 08 outputs 5 V when positioning complete, else 0 V.
// RQ7: Code 0C outputs 5 V when distribution complete, else 0 V.
// RQ8: Code 0B outputs 1 V for first gain set, 2 V for second.
// RQ9: Code 0D outputs external encoder speed at 1 V per 1,000 min-1.
// RQ10: Code 10 outputs DC bus voltage at 1 V per 100 V.
// RQ11: Software must not program reserved selection code 06.
// RQ12: Output equals minus (quantity times magnification plus offset).
// RQ13: Signed offset per channel, -10,000..10,000 in 0.1 V, default 0, immediate.
// RQ14: Signed magnification per channel, -10,000..10,000 in 0.01, default 100, immediate.
// RQ15: Output code has 16-bit resolution.
// RQ16: Plus or minus 8 V spans the usable code range.
// RQ17: Computed value saturates at code range ends, never wraps.
// RQ18: Both codes update once per control cycle with latest settings.
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

// Register indices; byte address is four times the index
`define AMS_IDX_SEL1       16'h2006
`define AMS_IDX_SEL2       16'h2007
`define AMS_IDX_OFF1       16'h2550
`define AMS_IDX_OFF2       16'h2551
`define AMS_IDX_MAG1       16'h2552
`define AMS_IDX_MAG2       16'h2553
`define AMS_IDX_CODE1      16'h2580
`define AMS_IDX_CODE2      16'h2581

// Reset values
`define AMS_RST_SEL1       16'h0002
`define AMS_RST_SEL2       16'h0000
`define AMS_RST_OFF        16'h0000
`define AMS_RST_MAG        16'h0064

// Selection field position
`define AMS_SEL_LSB        0
`define AMS_SEL_MSB        7

// Setting limit for offset and magnification
`define AMS_SET_LIMIT      16'h2710

// Per-unit factors in 0.1 mV units
`define AMS_F_SPEED        16'h000A
`define AMS_F_TORQUE       16'h0001
`define AMS_F_POSDEV       16'h01F4
`define AMS_F_LOADDEV      16'h0064
`define AMS_F_DCBUS        16'h0064

// Fixed levels in 0.1 mV units
`define AMS_LVL_1V         48'h0000_0000_2710
`define AMS_LVL_2V         48'h0000_0000_4E20
`define AMS_LVL_5V         48'h0000_0000_C350

// Offset step of 0.1 V expressed against the magnification scale of 100
`define AMS_OFF_WEIGHT     21'h186A0

// 32767 / (80000 * 100) scaled by 2^32: maps +-8 V onto the code range
`define AMS_CODE_K         26'h10C6D61
`define AMS_CODE_SHIFT     32
`define AMS_CODE_MAX       16'h7FFF
`define AMS_CODE_MIN       16'h8000

`endif

// ===== shared/ams_pkg.sv
// Types shared by the analog monitor scaler
package ams_pkg;

	// Monitored quantities from the servo loops, same clock domain
	typedef struct packed {
		logic signed [31:0] motor_speed;     // min-1 or mm/s
		logic signed [31:0] speed_ref;       // min-1 or mm/s
		logic signed [31:0] torque_ref;      // 0.01 % rated
		logic signed [31:0] pos_dev;         // reference units
		logic signed [31:0] pos_amp_dev;     // encoder pulses after gear
		logic signed [31:0] pos_ref_speed;   // min-1 or mm/s
		logic signed [31:0] load_motor_dev;  // reference units
		logic signed [31:0] speed_ff;        // min-1 or mm/s
		logic signed [31:0] torque_ff;       // 0.01 % rated
		logic signed [31:0] ext_enc_speed;   // min-1 at motor shaft
		logic signed [31:0] dc_bus;          // volts
		logic               pos_ctrl;        // position control active
		logic               pos_done;        // positioning complete
		logic               gain2;           // second gain set active
		logic               dist_done;       // reference distribution complete
	} monitor_inputs_t;

	// Selection codes
	typedef enum logic [7:0] {
		SEL_MOTOR_SPEED   = 8'h00,
		SEL_SPEED_REF     = 8'h01,
		SEL_TORQUE_REF    = 8'h02,
		SEL_POS_DEV       = 8'h03,
		SEL_POS_AMP_DEV   = 8'h04,
		SEL_POS_REF_SPEED = 8'h05,
		SEL_RESERVED      = 8'h06,
		SEL_LOAD_DEV      = 8'h07,
		SEL_POS_DONE      = 8'h08,
		SEL_SPEED_FF      = 8'h09,
		SEL_TORQUE_FF     = 8'h0A,
		SEL_ACTIVE_GAIN   = 8'h0B,
		SEL_DIST_DONE     = 8'h0C,
		SEL_EXT_SPEED     = 8'h0D,
		SEL_DC_BUS        = 8'h10
	} sel_code_t;

endpackage

// ===== verif/ams_instrument.sv
// Measuring instrument model sampling both DAC codes on each load pulse
`timescale 1ns/1ps
module ams_instrument (
	input  wire logic        clk_in,
	input  wire logic        load_in,
	input  wire logic [15:0] code1_in,
	input  wire logic [15:0] code2_in,
	output logic             got_out,
	output logic [15:0]      cap1_out,
	output logic [15:0]      cap2_out
);
	// Capture both channels together when the converter loads
	always_ff @(posedge clk_in) begin
		got_out <= load_in;
		if (load_in) begin
			cap1_out <= code1_in;
			cap2_out <= code2_in;
		end
	end
endmodule

// ===== verif/ams_monitor.sv
// Port assertions for the analog monitor scaler
`timescale 1ns/1ps
module ams_monitor (
	input wire logic        CORE_CLK_IN,
	input wire logic        SRST_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        CTRL_TICK_IN,
	input wire logic [15:0] MON1_CODE_OUT,
	input wire logic [15:0] MON2_CODE_OUT,
	input wire logic        DAC_LOAD_OUT
);
	// ----------------------------------------
	// Register bus and output timing
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (SRST_IN);
	a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	a_ready_wait: assert property (PSEL_IN && PENABLE_IN && !$past(PENABLE_IN) |-> !PREADY_OUT ##1 PREADY_OUT)
		else $error("ready not after one wait state");
	a_ready_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
		else $error("ready outside access");
	a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	a_err_zero: assert property (PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
		else $error("error with read data");
	a_load_tick: assert property (CTRL_TICK_IN |=> DAC_LOAD_OUT)
		else $error("tick without load");
	a_load_only: assert property (DAC_LOAD_OUT |-> $past(CTRL_TICK_IN))
		else $error("load without tick");
	a_ch1_hold: assert property (!DAC_LOAD_OUT |-> $stable(MON1_CODE_OUT))
		else $error("channel 1 code moved");
	a_ch2_hold: assert property (!DAC_LOAD_OUT |-> $stable(MON2_CODE_OUT))
		else $error("channel 2 code moved");
	a_reset_clear: assert property ($fell(SRST_IN) |-> MON1_CODE_OUT == 16'h0 && MON2_CODE_OUT == 16'h0)
		else $error("codes not cleared by reset");
endmodule
bind analog_monitor_output_scaler ams_monitor u_mon (.CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .CTRL_TICK_IN(CTRL_TICK_IN), .MON1_CODE_OUT(MON1_CODE_OUT),
	.MON2_CODE_OUT(MON2_CODE_OUT), .DAC_LOAD_OUT(DAC_LOAD_OUT));

// ===== verif/tb.sv
// Self-checking bench for the analog monitor scaler
`timescale 1ns/1ps
`include "ams_cfg.svh"
module tb;
	import ams_pkg::*;
	logic            clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, tick = 0, got;
	logic [17:0]     pa = 0;
	logic [31:0]     pwd = 0, prd;
	logic            prdy, perr, load;
	logic [15:0]     c1, c2, g1, g2, e1;
	monitor_inputs_t mon = '0;
	int              err_count = 0, cmp_count = 0, cyc = 0;
	logic [33:0]     rq[$];
	logic [31:0]     cq[$];
	logic [7:0]      codes[14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10}; // Reserved 06 never programmed
	always #4 clk = ~clk;
	analog_monitor_output_scaler DUT (.CORE_CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
		.PSLVERR_OUT(perr), .MON_IN(mon), .CTRL_TICK_IN(tick), .MON1_CODE_OUT(c1),
		.MON2_CODE_OUT(c2), .DAC_LOAD_OUT(load));
	ams_instrument u_ins (.clk_in(clk), .load_in(load), .code1_in(c1), .code2_in(c2),
		.got_out(got), .cap1_out(g1), .cap2_out(g2));
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task complete_run;
		err_count += rq.size() + cq.size(); // Notes never answered count as mismatches
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk_reg(logic [32:0] a, logic [32:0] e);
		cmp_count++;
		if (a !== e) begin
			err_count++;
			$display("CHECK FAILED %0t bus got %h want %h", $time, a, e);
		end
	endtask
	task chk_dac(logic [31:0] a, logic [31:0] e);
		cmp_count++;
		if (a !== e) begin
			err_count++;
			$display("CHECK FAILED %0t codes got %h want %h", $time, a, e);
		end
	endtask
	// Compare bus answers and loaded codes with the oldest notes
	always @(posedge clk) begin
		logic [33:0] n;
		if (prdy === 1'b1) begin
			n = rq.size() > 0 ? rq.pop_front() : ~34'h0; // Unexpected answer never matches
			chk_reg({perr, n[0] ? 32'h0 : prd}, {n[1], n[33:2]});
		end
		if (got === 1'b1)
			chk_dac({g1, g2}, cq.size() > 0 ? cq.pop_front() : ~{g1, g2});
		if (++cyc == 20000) begin
			err_count++;
			complete_run;
		end
	end
	// ----------------------------------------
	// Stimulus helpers
	// ----------------------------------------
	function automatic logic [17:0] ad(logic [15:0] i);
		return {i, 2'b00};
	endfunction
	function automatic int r(int m);
		return int'($urandom_range(2 * m)) - m;
	endfunction
	function automatic longint qv(logic [7:0] s);
		case (s)
			8'h00: return longint'(mon.motor_speed) * `AMS_F_SPEED;
			8'h01: return longint'(mon.speed_ref) * `AMS_F_SPEED;
			8'h05: return longint'(mon.pos_ref_speed) * `AMS_F_SPEED;
			8'h09: return longint'(mon.speed_ff) * `AMS_F_SPEED;
			8'h02: return longint'(mon.torque_ref);
			8'h0A: return longint'(mon.torque_ff);
			8'h03: return mon.pos_ctrl ? longint'(mon.pos_dev) * `AMS_F_POSDEV : 0;
			8'h07: return longint'(mon.load_motor_dev) * `AMS_F_LOADDEV;
			8'h04: return longint'(mon.pos_amp_dev) * `AMS_F_POSDEV;
			8'h08: return mon.pos_done ? `AMS_LVL_5V : 0;
			8'h0C: return mon.dist_done ? `AMS_LVL_5V : 0;
			8'h0B: return mon.gain2 ? `AMS_LVL_2V : `AMS_LVL_1V;
			8'h0D: return longint'(mon.ext_enc_speed) * `AMS_F_SPEED;
			default: return longint'(mon.dc_bus) * `AMS_F_DCBUS;
		endcase
	endfunction
	// Inverted scaled sum mapped onto the code span with clamping
	function automatic logic [15:0] ex(longint v, int m, int o);
		longint p;
		p = ((-(v * m) - longint'(o) * 64'sh186A0) * 64'sh10C6D61) >>> 32;
		return p > 64'sh7FFF ? 16'h7FFF : p < -64'sh8000 ? 16'h8000 : p[15:0];
	endfunction
	task apb(logic w, logic [17:0] a, logic [31:0] d, logic [31:0] e, logic er);
		rq.push_back({e, er, w});
		psel <= 1;
		pen <= 0;
		pw <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk) pen <= 1;
		do @(posedge clk); while (prdy !== 1'b1);
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int m1, m2, o1, o2, i;
		void'($urandom(27040));
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		apb(0, ad(`AMS_IDX_SEL1), 0, 32'h2, 0);
		apb(0, ad(`AMS_IDX_SEL2), 0, 32'h0, 0);
		apb(0, ad(`AMS_IDX_OFF2), 0, 32'h0, 0);
		apb(0, ad(`AMS_IDX_MAG1), 0, 32'h64, 0);
		apb(1, ad(`AMS_IDX_OFF1), 32'h2711, 0, 1);
		apb(1, ad(`AMS_IDX_MAG2), -32'sh2711, 0, 1);
		apb(0, ad(`AMS_IDX_OFF1), 0, 32'h0, 0);
		apb(0, ad(`AMS_IDX_MAG2), 0, 32'h64, 0);
		apb(0, 18'h08019, 0, 0, 1);
		apb(0, ad(16'h2008), 0, 0, 1);
		apb(1, ad(`AMS_IDX_CODE1), 32'h1, 0, 1);
		for (i = 0; i < 14; i++) begin
			m1 = r(i[0] ? 32'h2710 : 32'h12C);
			m2 = r(i[0] ? 32'h2710 : 32'h12C);
			o1 = r(i[0] ? 32'h2710 : 32'h32);
			o2 = r(i[0] ? 32'h2710 : 32'h32);
			if (i == 1) begin
				o1 = `AMS_SET_LIMIT;
				m2 = -int'(`AMS_SET_LIMIT);
			end
			apb(1, ad(`AMS_IDX_SEL1), {16'h0, 8'($urandom), codes[i]}, 0, 0);
			apb(1, ad(`AMS_IDX_SEL2), {16'h0, 8'($urandom), codes[13 - i]}, 0, 0);
			apb(1, ad(`AMS_IDX_MAG1), m1, 0, 0);
			apb(1, ad(`AMS_IDX_MAG2), m2, 0, 0);
			apb(1, ad(`AMS_IDX_OFF1), o1, 0, 0);
			apb(1, ad(`AMS_IDX_OFF2), o2, 0, 0);
			mon <= {r(32'h1770), r(32'h1770), r(32'h7530), r(32'hC8), r(32'hC8), r(32'h1770),
				r(32'hC8), r(32'h1770), r(32'h7530), r(32'h1770), int'($urandom_range(32'h190)), 4'($urandom)};
			repeat (4) @(posedge clk);
			tick <= 1;
			e1 = ex(qv(codes[i]), m1, o1);
			cq.push_back({e1, ex(qv(codes[13 - i]), m2, o2)});
			@(posedge clk) tick <= 0;
		end
		apb(0, ad(`AMS_IDX_CODE1), 0, {16'h0, e1}, 0);
		repeat (4) @(posedge clk);
		// Mid-run reset must restore the SEL1, OFF1 and MAG2 defaults and clear the channel 2 code
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		apb(0, ad(`AMS_IDX_SEL1), 0, 32'h2, 0);
		apb(0, ad(`AMS_IDX_OFF1), 0, 32'h0, 0);
		apb(0, ad(`AMS_IDX_MAG2), 0, 32'h64, 0);
		apb(0, ad(`AMS_IDX_CODE2), 0, 32'h0, 0);
		repeat (4) @(posedge clk);
		complete_run;
	end
endmodule
